// file: card_reader_pkg.sv
package card_reader_pkg;

  // Device address that the controller answers on the processor bus.
  localparam logic [7:0] DEVICE_ADDR = 8'h04;

  // Status byte positions; bit 7 of the byte is its most significant bit.
  localparam int ST_OVERRUN  = 7;
  localparam int ST_TROUBLE  = 6;
  localparam int ST_HOPPER   = 5;
  localparam int ST_NOMOTION = 4;
  localparam int ST_BUSY     = 3;
  localparam int ST_ERRSUM   = 2;
  localparam int ST_EOM      = 1;
  localparam int ST_UNAVAIL  = 0;

  // Command byte positions, same bit order as the status byte.
  localparam int CMD_DISABLE = 7;
  localparam int CMD_ENABLE  = 6;
  localparam int CMD_FEED    = 5;

  // Synchronised reader pin bundle layout and its quiet value.
  localparam int PIN_W       = 16;
  localparam int PIN_STATION = 15;
  localparam int PIN_STROBE  = 14;
  localparam int PIN_HOPPER  = 13;
  localparam int PIN_OPRESET = 12;
  localparam logic [PIN_W-1:0] PIN_IDLE = 16'h0FFF;

  // Latched reader error positions.
  localparam int ERR_W       = 4;
  localparam int ERR_MISS    = 0;
  localparam int ERR_TRANSIT = 1;
  localparam int ERR_LIGHT   = 2;
  localparam int ERR_DARK    = 3;

  // Card geometry: twelve rows, 80 columns.
  localparam int ROWS = 12;
  localparam int COL_W = 7;
  localparam logic [COL_W-1:0] LAST_COLUMN = 7'h50;
  localparam logic [ROWS-1:0] ALL_LIGHT = 12'hFFF;
  localparam logic [ROWS-1:0] ALL_DARK = 12'h000;

  // Reset value of the interrupt enable.
  localparam logic INT_EN_RESET = 1'b0;

  // Timing: 25 MHz clock, column period and pick window in ns.
  localparam int CLK_PERIOD_NS = 40;
  localparam int COLUMN_NS = 2000;
  localparam int COLUMN_CYCLES = COLUMN_NS / CLK_PERIOD_NS;
  localparam int TRANSIT_THIRDS = 256;
  localparam int TRANSIT_CYCLES = COLUMN_CYCLES * TRANSIT_THIRDS / 3;
  localparam int TRANSIT_TOL_CYCLES = COLUMN_CYCLES / 2;
  localparam int PICK_NS = 200000;
  localparam int PICK_CYCLES = PICK_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // Column buffer depth.
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {FEED_IDLE, FEED_PICK, FEED_TRANSIT} feed_state_e;

endpackage : card_reader_pkg

// file: column_buffer.sv
`timescale 1ns/1ps
module column_buffer
  import card_reader_pkg::*;
#(
  parameter int WIDTH = ROWS,
  parameter int DEPTH = BUF_DEPTH
)
(
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  // Pointers wrap at the depth, which need not be a power of two.
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : step

  // Handshakes on both sides; full and empty follow the count exactly.
  assign in_ready_out  = (count != FULL);
  assign out_valid_out = (count != '0);
  assign out_data_out  = slots[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Occupancy and pointer bookkeeping.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= step(wr_ptr);
      if (pop)
        rd_ptr <= step(rd_ptr);
      if (push && !pop)
        count <= count + (PW+1)'(1);
      else if (pop && !push)
        count <= count - (PW+1)'(1);
    end
  end

  // Storage needs no reset; a slot is only read after it was written.
  always_ff @(posedge mclk_in)
  begin
    if (push)
      slots[wr_ptr] <= in_data_in;
  end

endmodule : column_buffer

// file: card_reader_controller.sv
`timescale 1ns/1ps
module card_reader_controller
  import card_reader_pkg::*;
#(
  parameter int TRANSIT_CYC = TRANSIT_CYCLES,
  parameter int PICK_CYC    = PICK_CYCLES
)
(
  // Clock and processor clear
  input  wire logic            mclk_in,
  input  wire logic            reset_n_in,
  // Processor I/O bus
  input  wire logic [7:0]      addr_in,
  input  wire logic            sense_in,
  input  wire logic            command_in,
  input  wire logic            read_in,
  input  wire logic [7:0]      wr_data_in,
  output logic                 ack_out,
  output logic [7:0]           rd_data_out,
  output logic                 interrupt_out,
  // Reader mechanism
  input  wire logic            station_card_in,
  input  wire logic            column_strobe_in,
  input  wire logic [ROWS-1:0] photocell_in,
  input  wire logic            hopper_out_of_cards_in,
  input  wire logic            operator_reset_in,
  output logic                 pick_out,
  output logic [ERR_W-1:0]     error_lamps_out,
  output logic                 buffer_ready_out
);

  localparam logic [TIMER_W-1:0] T_LO =
    TIMER_W'(TRANSIT_CYC - TRANSIT_TOL_CYCLES);
  localparam logic [TIMER_W-1:0] T_HI =
    TIMER_W'(TRANSIT_CYC + TRANSIT_TOL_CYCLES);
  localparam logic [TIMER_W-1:0] PICK_LAST = TIMER_W'(PICK_CYC - 1);

  logic [PIN_W-1:0]   sync1;
  logic [PIN_W-1:0]   sync2;
  logic [PIN_W-1:0]   sync3;
  logic [PIN_W-1:0]   pin_q;
  logic [PIN_W-1:0]   pin_d;
  logic [ROWS-1:0]    cells;
  logic               station;
  logic               station_rise;
  logic               station_fall;
  logic               strobe_rise;
  logic               op_reset;
  feed_state_e        state;
  logic [TIMER_W-1:0] timer;
  logic [COL_W-1:0]   col_cnt;
  logic               dark_seen;
  logic [ERR_W-1:0]   errors;
  logic [ERR_W-1:0]   err_set;
  logic               hopper_empty;
  logic               overrun;
  logic               int_en;
  logic               second_half;
  logic               trouble;
  logic               no_motion;
  logic               busy;
  logic [7:0]         status;
  logic               sel;
  logic               sense_sel;
  logic               cmd_sel;
  logic               read_sel;
  logic               feed_accept;
  logic               push;
  logic               fifo_in_ready;
  logic               fifo_valid;
  logic [ROWS-1:0]    fifo_data;
  logic               pop;

  // Packs six rows into a data byte; the two top bits always read zero.
  function automatic logic [7:0] pack_rows(input logic [ROWS-1:0] w,
                                           input logic lower);
    pack_rows = lower ? {2'b00, w[5:0]} : {2'b00, w[11:6]};
  endfunction : pack_rows

  // Reader pins pass three flops; a change counts once stages two and
  // three agree, which also rejects single-cycle glitches on the cable.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      pin_q <= PIN_IDLE;
      pin_d <= PIN_IDLE;
    end
    else
    begin
      sync1 <= {station_card_in, column_strobe_in, hopper_out_of_cards_in,
                operator_reset_in, photocell_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= (sync2 & sync3) | (pin_q & (sync2 ^ sync3));
      pin_d <= pin_q;
    end
  end

  // Edges and levels of the filtered pins.
  assign cells        = pin_q[ROWS-1:0];
  assign station      = pin_q[PIN_STATION];
  assign station_rise = station && !pin_d[PIN_STATION];
  assign station_fall = !station && pin_d[PIN_STATION];
  assign strobe_rise  = pin_q[PIN_STROBE] && !pin_d[PIN_STROBE];
  assign op_reset     = pin_q[PIN_OPRESET] && !pin_d[PIN_OPRESET];

  // Bus decode: nothing is taken unless the device address matches.
  assign sel       = (addr_in == DEVICE_ADDR);
  assign sense_sel = sel && sense_in;
  assign cmd_sel   = sel && command_in;
  assign read_sel  = sel && read_in;

  // Summary flags built from the latched state.
  assign trouble   = |errors;
  assign no_motion = (state == FEED_IDLE) || hopper_empty;
  assign busy      = !fifo_valid;

  // A feed is refused while an error or an empty hopper stands, and
  // while a card is already moving.
  assign feed_accept = cmd_sel && wr_data_in[CMD_FEED] && !trouble
                       && !hopper_empty && (state == FEED_IDLE);

  // Every strobe of a card in transit with no error standing pushes a column, blank or not, and the buffer drops it when full;
  // strobes past column 80 are not real columns and are dropped.
  assign push = strobe_rise && station && (state == FEED_TRANSIT)
                && !trouble && (col_cnt < LAST_COLUMN);

  // Second data read of a column retires it from the buffer.
  assign pop = read_sel && second_half && fifo_valid;

  // Status byte assembly.
  always_comb
  begin
    status              = 8'h00;
    status[ST_OVERRUN]  = overrun;
    status[ST_TROUBLE]  = trouble;
    status[ST_HOPPER]   = hopper_empty;
    status[ST_NOMOTION] = no_motion;
    status[ST_BUSY]     = busy;
    status[ST_ERRSUM]   = overrun || trouble || hopper_empty || no_motion;
    status[ST_EOM]      = no_motion || hopper_empty;
    status[ST_UNAVAIL]  = trouble;
  end

  // Two-entry buffer so a slow host does not lose the column in flight.
  column_buffer #(
    .WIDTH (ROWS),
    .DEPTH (BUF_DEPTH)
  ) u_column_buffer (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push),
    .in_data_in    (cells),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (pop)
  );

  // Feed sequencer: pick a card, then time its pass through the station.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      state    <= FEED_IDLE;
      timer    <= 16'h0000;
      pick_out <= 1'b0;
    end
    else
    begin
      timer <= timer + 16'h0001;
      case (state)
        FEED_IDLE:
        begin
          if (feed_accept)
          begin
            state    <= FEED_PICK;
            timer    <= 16'h0000;
            pick_out <= 1'b1;
          end
        end
        FEED_PICK:
        begin
          if (station_rise)
          begin
            state    <= FEED_TRANSIT;
            timer    <= 16'h0000;
            pick_out <= 1'b0;
          end
          else if (timer == PICK_LAST)
          begin
            state    <= FEED_IDLE;
            pick_out <= 1'b0;
          end
        end
        FEED_TRANSIT:
        begin
          if (station_fall || timer > T_HI || trouble)
            state <= FEED_IDLE;
        end
        default:
        begin
          state    <= FEED_IDLE;
          pick_out <= 1'b0;
        end
      endcase
    end
  end

  // Column count and dark check, both restarted as a card enters.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      col_cnt   <= '0;
      dark_seen <= 1'b0;
    end
    else if (station_rise)
    begin
      col_cnt   <= '0;
      dark_seen <= 1'b0;
    end
    else
    begin
      if (strobe_rise && station && col_cnt != '1)
        col_cnt <= col_cnt + 7'h01;
      if (station && cells == ALL_DARK
          && (col_cnt == '0 || col_cnt >= LAST_COLUMN))
        dark_seen <= 1'b1;
    end
  end

  // Error causes as set requests; the light check stays raised while a cell reads dark with no card.
  always_comb
  begin
    err_set              = '0;
    err_set[ERR_MISS]    = (state == FEED_PICK) && !station_rise
                           && (timer == PICK_LAST);
    err_set[ERR_TRANSIT] = (state == FEED_TRANSIT)
                           && ((station_fall && timer < T_LO) || timer > T_HI);
    err_set[ERR_LIGHT]   = !station && !pin_d[PIN_STATION]
                           && cells != ALL_LIGHT;
    err_set[ERR_DARK]    = (state == FEED_TRANSIT) && station_fall
                           && !dark_seen;
  end

  // Errors hold until the operator resets; a new cause wins the tie.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      errors <= '0;
    else
      errors <= (errors & ~{ERR_W{op_reset}}) | err_set;
  end

  // Hopper empty latches as the last card leaves the read station.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      hopper_empty <= 1'b0;
    else if (station_fall && pin_q[PIN_HOPPER])
      hopper_empty <= 1'b1;
    else if (op_reset)
      hopper_empty <= 1'b0;
  end

  // Overrun: a column lands while the previous one is still unread.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      overrun <= 1'b0;
    else if (push && fifo_valid)
      overrun <= 1'b1;
    else if (feed_accept)
      overrun <= 1'b0;
  end

  // Interrupt enable; a byte holding both bits leaves it disabled.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      int_en <= INT_EN_RESET;
    else if (cmd_sel && wr_data_in[CMD_DISABLE])
      int_en <= 1'b0;
    else if (cmd_sel && wr_data_in[CMD_ENABLE])
      int_en <= 1'b1;
  end

  // Byte pointer within the head column; idle reads do not advance it.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      second_half <= 1'b0;
    else if (read_sel && fifo_valid)
      second_half <= !second_half;
  end

  // Bus answers: acknowledge and read data, registered.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      ack_out     <= 1'b0;
      rd_data_out <= 8'h00;
    end
    else
    begin
      ack_out <= sense_sel || cmd_sel || read_sel;
      if (sense_sel)
        rd_data_out <= status;
      else if (read_sel)
        rd_data_out <= fifo_valid ? pack_rows(fifo_data, second_half)
                                  : 8'h00;
    end
  end

  // One interrupt pulse per pushed column, whether or not the buffer had room for it, plus pin-side outputs.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      interrupt_out    <= 1'b0;
      error_lamps_out  <= '0;
      buffer_ready_out <= 1'b0;
    end
    else
    begin
      interrupt_out    <= push && int_en;
      error_lamps_out  <= errors;
      buffer_ready_out <= fifo_in_ready;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  property p_addr_decode;
    ack_out |-> $past(addr_in) == DEVICE_ADDR;
  endproperty
  a_addr_decode: assert property (p_addr_decode)
    else $error("ack for a foreign address");

  property p_overrun;
    push && fifo_valid |=> status[ST_OVERRUN] && status[ST_ERRSUM];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not reported");

  property p_error_flags;
    (|err_set) |=> status[ST_TROUBLE] && status[ST_UNAVAIL];
  endproperty
  a_error_flags: assert property (p_error_flags)
    else $error("trouble or unavailable missing after error");

  property p_feed_refused;
    cmd_sel && wr_data_in[CMD_FEED] && (trouble || hopper_empty)
      && state == FEED_IDLE |=> state == FEED_IDLE && !pick_out;
  endproperty
  a_feed_refused: assert property (p_feed_refused)
    else $error("feed taken despite trouble or empty hopper");

  property p_hopper_hold;
    hopper_empty && !op_reset ##1 !op_reset |-> (hopper_empty && no_motion) [*2];
  endproperty
  a_hopper_hold: assert property (p_hopper_hold)
    else $error("hopper empty dropped without operator reset");

  property p_feed_motion;
    feed_accept |=> !no_motion ##1 pick_out;
  endproperty
  a_feed_motion: assert property (p_feed_motion)
    else $error("no motion still set after accepted feed");

  property p_status_sum;
    sense_sel |=> rd_data_out[ST_ERRSUM] == (|rd_data_out[7:4])
      && (!rd_data_out[ST_NOMOTION] || rd_data_out[ST_EOM]);
  endproperty
  a_status_sum: assert property (p_status_sum)
    else $error("summary or end of medium inconsistent");

  property p_busy_clears;
    push && !fifo_valid |=> !status[ST_BUSY];
  endproperty
  a_busy_clears: assert property (p_busy_clears)
    else $error("busy still set with column waiting");

  property p_irq_disabled;
    cmd_sel && wr_data_in[CMD_DISABLE] ##1 (!cmd_sel)[*3] |=> !interrupt_out [*2];
  endproperty
  a_irq_disabled: assert property (p_irq_disabled)
    else $error("interrupt while disabled");

  property p_irq_column;
    push && int_en |=> interrupt_out ##1 !interrupt_out;
  endproperty
  a_irq_column: assert property (p_irq_column)
    else $error("column interrupt not a single pulse");

  property p_data_upper;
    read_sel && fifo_valid && !second_half
      |=> rd_data_out == {2'b00, $past(fifo_data[11:6])};
  endproperty
  a_data_upper: assert property (p_data_upper)
    else $error("first data byte carries wrong rows");

  property p_pick_miss;
    state == FEED_PICK ##0 (!station_rise)[*1] ##0 timer == PICK_LAST
      |=> errors[ERR_MISS] && state == FEED_IDLE;
  endproperty
  a_pick_miss: assert property (p_pick_miss)
    else $error("missed pick not flagged");

  c_feed:    cover property (feed_accept);
  c_column:  cover property (push ##[1:200] pop);
  c_overrun: cover property (push && fifo_valid);
  c_transit: cover property (state == FEED_TRANSIT && station_fall);

endmodule : card_reader_controller

// file: card_reader_model.sv
`timescale 1ns/1ps
module card_reader_model
  import card_reader_pkg::*;
#(
  parameter int COL_CYC = 12,
  parameter int TRANSIT = 1000
)
(
  // Controller side
  input  wire logic            mclk_in,
  input  wire logic            pick_in,
  // Scenario controls
  input  wire logic [2:0]      fault_in,
  input  wire logic            last_card_in,
  input  wire logic            op_reset_in,
  // Reader pins
  output logic                 station_card_out,
  output logic                 column_strobe_out,
  output logic [ROWS-1:0]      photocell_out,
  output logic                 hopper_out_of_cards_out,
  output logic                 operator_reset_out
);
  // Hopper and operator switches follow the scenario directly.
  assign hopper_out_of_cards_out = last_card_in;
  assign operator_reset_out      = op_reset_in;

  // Hole pattern of a column; column 2 is blank so all-zero data is seen.
  function automatic logic [ROWS-1:0] col_rows(input int n);
    return (n == 2) ? ALL_DARK : ROWS'(n * 291);
  endfunction : col_rows

  // One card per pick. Faults 1 to 4 miss the pick, cut the transit short,
  // leak no light on one cell, or never go dark around the columns.
  initial
  begin
    station_card_out  = 1'b0;
    column_strobe_out = 1'b0;
    photocell_out     = ALL_LIGHT;
    forever
    begin
      @(posedge mclk_in);
      photocell_out <= (fault_in == 3'd3) ? 12'hFFE : ALL_LIGHT;
      if (pick_in && fault_in != 3'd1)
      begin
        repeat (10) @(posedge mclk_in);
        station_card_out <= 1'b1;
        photocell_out    <= (fault_in == 3'd4) ? ALL_LIGHT : ALL_DARK;
        repeat (20) @(posedge mclk_in);
        for (int n = 1; n <= 80 && fault_in != 3'd2; n++)
        begin
          photocell_out     <= col_rows(n);
          column_strobe_out <= 1'b1;
          repeat (2) @(posedge mclk_in);
          column_strobe_out <= 1'b0;
          repeat (COL_CYC - 2) @(posedge mclk_in);
        end
        photocell_out <= (fault_in == 3'd4) ? ALL_LIGHT : ALL_DARK;
        repeat ((fault_in == 3'd2) ? 1 : TRANSIT - 20 - 80 * COL_CYC) @(posedge mclk_in);
        station_card_out <= 1'b0;
        photocell_out    <= ALL_LIGHT;
      end
    end
  end
endmodule : card_reader_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import card_reader_pkg::*;

  // Short columns and transit keep a card near a thousand cycles.
  localparam int TRANSIT = 1000;

  logic             mclk_in    = 1'b0;
  logic             reset_n_in = 1'b0;
  logic [7:0]       addr_in    = 8'h00;
  logic             sense_in   = 1'b0;
  logic             command_in = 1'b0;
  logic             read_in    = 1'b0;
  logic [7:0]       wr_data_in = 8'h00;
  logic             ack_out;
  logic [7:0]       rd_data_out;
  logic             interrupt_out;
  logic             station_card;
  logic             column_strobe;
  logic [ROWS-1:0]  photocell;
  logic             hopper_pin;
  logic             op_reset_pin;
  logic             pick_out;
  logic [ERR_W-1:0] error_lamps_out;
  logic             buffer_ready_out;
  logic [2:0]       fault      = 3'd0;
  logic             last_card  = 1'b0;
  logic             op_reset   = 1'b0;
  int               error_cnt  = 0;
  int               num_checks = 0;
  int               irq_cnt    = 0;

  // Free-running 25 MHz clock.
  always #20 mclk_in = ~mclk_in;

  card_reader_controller #(.TRANSIT_CYC(TRANSIT), .PICK_CYC(50)) uut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .sense_in(sense_in),
    .command_in(command_in), .read_in(read_in), .wr_data_in(wr_data_in), .ack_out(ack_out),
    .rd_data_out(rd_data_out), .interrupt_out(interrupt_out), .station_card_in(station_card),
    .column_strobe_in(column_strobe), .photocell_in(photocell),
    .hopper_out_of_cards_in(hopper_pin), .operator_reset_in(op_reset_pin),
    .pick_out(pick_out), .error_lamps_out(error_lamps_out),
    .buffer_ready_out(buffer_ready_out));

  card_reader_model #(.COL_CYC(12), .TRANSIT(TRANSIT)) model (
    .mclk_in(mclk_in), .pick_in(pick_out), .fault_in(fault), .last_card_in(last_card),
    .op_reset_in(op_reset), .station_card_out(station_card),
    .column_strobe_out(column_strobe), .photocell_out(photocell),
    .hopper_out_of_cards_out(hopper_pin), .operator_reset_out(op_reset_pin));

  // Interrupt pulses are counted so a disabled card can be seen to raise none.
  always @(posedge mclk_in)
    if (interrupt_out === 1'b1)
      irq_cnt++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Kind 0 sense, 1 command, 2 read; the answer is sampled 1 ns after the edge that takes it.
  task automatic bus(input int kind, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ak);
    @(posedge mclk_in);
    addr_in    <= a;
    wr_data_in <= d;
    sense_in   <= (kind == 0);
    command_in <= (kind == 1);
    read_in    <= (kind == 2);
    @(posedge mclk_in);
    sense_in   <= 1'b0;
    command_in <= 1'b0;
    read_in    <= 1'b0;
    #1;
    q  = rd_data_out;
    ak = ack_out;
  endtask : bus

  // Access at the device address; a zero mask skips the data compare.
  task automatic acc(input int kind, input logic [7:0] d, input logic [7:0] mask,
                     input logic [7:0] exp, input string msg);
    logic [7:0] q;
    logic       ak;
    bus(kind, DEVICE_ADDR, d, q, ak);
    chk({7'h00, ak}, 8'h01, "no ack");
    if (mask !== 8'h00)
      chk(q & mask, exp, msg);
  endtask : acc

  task automatic wait_irq();
    for (int i = 0; i < 60 && interrupt_out !== 1'b1; i++)
    begin
      @(posedge mclk_in);
      #1;
    end
    chk({7'h00, interrupt_out}, 8'h01, "column interrupt");
  endtask : wait_irq

  // Reads a card at the pace of its interrupts, then polls until motion stops.
  task automatic read_card();
    logic [ROWS-1:0] p;
    logic [7:0]      s;
    logic            ak;
    for (int n = 1; n <= 80; n++)
    begin
      p = model.col_rows(n);
      wait_irq();
      acc(2, 8'h00, 8'hFF, {2'b00, p[11:6]}, "upper rows");
      acc(2, 8'h00, 8'hFF, {2'b00, p[5:0]}, "lower rows");
      acc(0, 8'h00, 8'h98, 8'h08, "status after column");
    end
    s = 8'h00;
    for (int i = 0; i < 200 && s[ST_EOM] !== 1'b1; i++)
      bus(0, DEVICE_ADDR, 8'h00, s, ak);
  endtask : read_card

  task automatic op_clear();
    repeat (10) @(posedge mclk_in);
    op_reset <= 1'b1;
    repeat (6) @(posedge mclk_in);
    op_reset <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask : op_clear

  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Main sequence: clear, address decode, three cards, then each reader fault.
  initial
  begin
    logic [7:0]      q;
    logic            ak;
    logic [ROWS-1:0] p;
    int              n0;
    logic [7:0]      bad [4];
    bad = '{8'h00, 8'h05, 8'h14, 8'hFF};
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    acc(0, 8'h00, 8'hFF, 8'h1E, "status after clear");
    acc(2, 8'h00, 8'hFF, 8'h00, "read while busy");
    foreach (bad[i])
    begin
      bus(1, bad[i], 8'h20, q, ak);
      chk({7'h00, ak}, 8'h00, "foreign command acked");
      bus(0, bad[i], 8'h00, q, ak);
      chk({7'h00, ak}, 8'h00, "foreign sense acked");
    end
    chk({7'h00, pick_out}, 8'h00, "foreign feed picked");
    acc(1, 8'h40, 8'h00, 8'h00, "");
    acc(1, 8'h20, 8'h00, 8'h00, "");
    acc(0, 8'h00, 8'hFF, 8'h08, "moving status");
    read_card();
    acc(0, 8'h00, 8'hFF, 8'h1E, "status after card");
    acc(1, 8'h80, 8'h00, 8'h00, "");
    acc(1, 8'h20, 8'h00, 8'h00, "");
    n0 = irq_cnt;
    repeat (TRANSIT + 100) @(posedge mclk_in);
    chk(8'(irq_cnt - n0), 8'h00, "interrupt while disabled");
    chk({7'h00, buffer_ready_out}, 8'h00, "buffer not full");
    acc(0, 8'h00, 8'hFF, 8'h96, "overrun status");
    for (int n = 1; n <= 2; n++)
    begin
      p = model.col_rows(n);
      acc(2, 8'h00, 8'hFF, {2'b00, p[11:6]}, "held upper rows");
      acc(2, 8'h00, 8'hFF, {2'b00, p[5:0]}, "held lower rows");
    end
    chk({7'h00, buffer_ready_out}, 8'h01, "buffer not drained");
    last_card <= 1'b1;
    acc(1, 8'h60, 8'h00, 8'h00, "");
    acc(0, 8'h00, 8'h90, 8'h00, "overrun kept by feed");
    read_card();
    acc(0, 8'h00, 8'hFF, 8'h3E, "hopper empty status");
    acc(1, 8'h20, 8'h00, 8'h00, "");
    acc(0, 8'h00, 8'hFF, 8'h3E, "feed taken on empty hopper");
    last_card <= 1'b0;
    op_clear();
    acc(0, 8'h00, 8'hFF, 8'h1E, "hopper not cleared");
    for (int f = 1; f <= 4; f++)
    begin
      fault <= 3'(f);
      acc(1, 8'h20, 8'h00, 8'h00, "");
      repeat (TRANSIT + 100) @(posedge mclk_in);
      acc(0, 8'h00, 8'h45, 8'h45, "trouble status");
      chk({7'h00, error_lamps_out[f - 1]}, 8'h01, "fault lamp");
      acc(1, 8'h20, 8'h00, 8'h00, "");
      repeat (20) @(posedge mclk_in);
      chk({7'h00, pick_out}, 8'h00, "feed taken in trouble");
      fault <= 3'd0;
      op_clear();
      acc(0, 8'h00, 8'h41, 8'h00, "trouble not cleared");
    end
    final_report();
  end

  // Cuts a hang short well beyond the expected run of about eight thousand cycles.
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : tb_top
